// *** dv/host_parallel_port_handshake_tb_top.sv ***
// Self-checking bench joining the host and device ends across the pin link.
`timescale 1ns/10ps
module host_parallel_port_handshake_tb_top
  import hpph_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sixteenBitMode = 1'b0;
  logic cpuCtrlWrite = 1'b0;
  logic cpuReadAddrWrite = 1'b0;
  logic cpuWriteAddrWrite = 1'b0;
  logic [31:0] cpuWriteData = 32'h0;
  logic [31:0] controlReg, readAddrCopy, writeAddrCopy, dmaReadAddr, dmaWriteAddr, dmaWriteData;
  logic dmaReadReq, dmaWriteValid, cmdReady, rspValid;
  logic dmaReadValid = 1'b0;
  logic [31:0] dmaReadData = 32'h0;
  logic dmaWriteReady = 1'b0;
  logic useAddrStrobe = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic [1:0] cmdSelect = 2'h0;
  logic cmdHalf = 1'b0;
  logic [31:0] cmdData = 32'h0;
  logic [31:0] rspData;
  logic stall = 1'b0;
  int seed = 32'h8e45;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] qRsp[$], qMask[$], qWr[$], qWrAddr[$];

  hpph_if i_hpph_if ();
  hpph_device i_hpph_device (.clk_sys(clk_sys), .rst(rst), .link(i_hpph_if),
    .sixteenBitMode(sixteenBitMode), .cpuCtrlWrite(cpuCtrlWrite),
    .cpuReadAddrWrite(cpuReadAddrWrite), .cpuWriteAddrWrite(cpuWriteAddrWrite),
    .cpuWriteData(cpuWriteData), .controlReg(controlReg), .readAddrCopy(readAddrCopy),
    .writeAddrCopy(writeAddrCopy), .dmaReadReq(dmaReadReq), .dmaReadAddr(dmaReadAddr),
    .dmaReadValid(dmaReadValid), .dmaReadData(dmaReadData), .dmaWriteValid(dmaWriteValid),
    .dmaWriteReady(dmaWriteReady), .dmaWriteAddr(dmaWriteAddr), .dmaWriteData(dmaWriteData));
  hpph_host i_hpph_host (.clk_sys(clk_sys), .rst(rst), .link(i_hpph_if),
    .useAddrStrobe(useAddrStrobe), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdRead(cmdRead), .cmdSelect(cmdSelect), .cmdHalf(cmdHalf), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData));
  hpph_link_props i_hpph_link_props (.clk_sys(clk_sys), .rst(rst),
    .hostChipSelectN(i_hpph_if.hostChipSelectN), .hostDataStrobeA(i_hpph_if.hostDataStrobeA),
    .hostDataStrobeB(i_hpph_if.hostDataStrobeB), .addressStrobeN(i_hpph_if.addressStrobeN),
    .hostRegisterSelect(i_hpph_if.hostRegisterSelect), .hostReadWrite(i_hpph_if.hostReadWrite),
    .halfwordSelect(i_hpph_if.halfwordSelect), .hostReadyN(i_hpph_if.hostReadyN),
    .devDataOe(i_hpph_if.devDataOe));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] memWord(input logic [31:0] a);
    return a ^ 32'hc3a5_0f1e;
  endfunction : memWord

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic waitReady();
    for (int i = 0; i < 300 && cmdReady !== 1'b1; i++) @(negedge clk_sys);
    if (cmdReady !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t host never ready", $time);
      print_verdict();
    end
  endtask : waitReady

  // Issues one host command from a falling edge and notes the expected response.
  task automatic hostCmd(input logic rd, input logic [1:0] sel, input logic half,
      input logic [31:0] d, input logic [31:0] expD, input logic [31:0] mask);
    waitReady();
    qRsp.push_back(expD);
    qMask.push_back(mask);
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdSelect = sel;
    cmdHalf = half;
    cmdData = d;
    @(negedge clk_sys);
    cmdValid = 1'b0;
  endtask : hostCmd

  always @(posedge clk_sys) begin : rspMon
    logic [31:0] e, m;
    if (rspValid === 1'b1 && qRsp.size() == 0) begin
      n_mismatch++;
      $display("[FAIL] %0t response without a command", $time);
    end else if (rspValid === 1'b1) begin
      e = qRsp.pop_front();
      m = qMask.pop_front();
      check32(rspData & m, e & m);
    end
    if (dmaWriteValid === 1'b1 && dmaWriteReady === 1'b1 && qWr.size() == 0) begin
      n_mismatch++;
      $display("[FAIL] %0t unexpected buffer word", $time);
    end else if (dmaWriteValid === 1'b1 && dmaWriteReady === 1'b1) begin
      check32(dmaWriteAddr, qWrAddr.pop_front());
      check32(dmaWriteData, qWr.pop_front());
    end
  end

  always @(negedge clk_sys) begin
    dmaWriteReady <= !stall && ($random(seed) % 2 != 0);
  end

  initial begin : dmaReadSide
    logic [31:0] a;
    forever begin
      @(posedge clk_sys);
      if (dmaReadReq === 1'b1) begin
        a = dmaReadAddr;
        repeat (1 + $unsigned($random(seed)) % 3) @(negedge clk_sys);
        dmaReadData = memWord(a);
        dmaReadValid = 1'b1;
        @(negedge clk_sys);
        dmaReadValid = 1'b0;
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    $display("[FAIL] %0t run did not finish", $time);
    print_verdict();
  end

  initial begin : mainSeq
    logic [31:0] a0, a1, d;
    a0 = 32'h0000_1000;
    a1 = 32'h0002_0040;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    hostCmd(1'b0, HPPH_SEL_ADDR, 1'b0, a0, 32'h0, 32'h0);
    hostCmd(1'b0, HPPH_SEL_CTRL, 1'b0, 32'h5, 32'h0, 32'h0);
    hostCmd(1'b1, HPPH_SEL_CTRL, 1'b0, 32'h0, 32'h5, '1);
    waitReady();
    check32(readAddrCopy, a0);
    check32(writeAddrCopy, a0);
    check32(controlReg, 32'h5);
    $display("test register access done");
    stall = 1'b1;
    for (int i = 0; i < 17; i++) begin
      d = $random(seed);
      qWrAddr.push_back(a0 + 32'(4 * i));
      qWr.push_back(d);
      hostCmd(1'b0, HPPH_SEL_DATA_INC, 1'b0, d, 32'h0, 32'h0);
    end
    repeat (8) @(negedge clk_sys);
    check32(32'(i_hpph_if.hostReadyN), 32'h1);
    stall = 1'b0;
    waitReady();
    check32(writeAddrCopy, a0 + 32'd68);
    $display("test buffered writes done");
    for (int i = 0; i < 3; i++) begin
      hostCmd(1'b1, HPPH_SEL_DATA_INC, 1'b0, 32'h0, memWord(a0 + 32'(4 * i)), '1);
    end
    hostCmd(1'b1, HPPH_SEL_DATA_FIX, 1'b0, 32'h0, memWord(a0 + 32'd12), '1);
    hostCmd(1'b1, HPPH_SEL_DATA_FIX, 1'b0, 32'h0, memWord(a0 + 32'd12), '1);
    $display("test word reads done");
    waitReady();
    sixteenBitMode = 1'b1;
    useAddrStrobe = 1'b1;
    hostCmd(1'b0, HPPH_SEL_ADDR, 1'b0, {2{a1[15:0]}}, 32'h0, 32'h0);
    hostCmd(1'b0, HPPH_SEL_ADDR, 1'b1, {2{a1[31:16]}}, 32'h0, 32'h0);
    d = $random(seed);
    qWrAddr.push_back(a1);
    qWr.push_back(d);
    hostCmd(1'b0, HPPH_SEL_DATA_INC, 1'b0, {2{d[15:0]}}, 32'h0, 32'h0);
    hostCmd(1'b0, HPPH_SEL_DATA_INC, 1'b1, {2{d[31:16]}}, 32'h0, 32'h0);
    d = memWord(a1);
    hostCmd(1'b1, HPPH_SEL_DATA_INC, 1'b0, 32'h0, {16'h0, d[15:0]}, 32'h0000ffff);
    hostCmd(1'b1, HPPH_SEL_DATA_INC, 1'b1, 32'h0, {16'h0, d[31:16]}, 32'h0000ffff);
    waitReady();
    check32(readAddrCopy, a1 + 32'd4);
    check32(writeAddrCopy, a1 + 32'd4);
    $display("test half-word mode done");
    cpuReadAddrWrite = 1'b1;
    cpuWriteData = 32'h0000_3000;
    @(negedge clk_sys);
    cpuReadAddrWrite = 1'b0;
    @(negedge clk_sys);
    check32(readAddrCopy, 32'h0000_3000);
    check32(writeAddrCopy, a1 + 32'd4);
    d = $random(seed);
    cpuWriteAddrWrite = 1'b1;
    cpuCtrlWrite = 1'b1;
    cpuWriteData = d;
    @(negedge clk_sys);
    cpuWriteAddrWrite = 1'b0;
    cpuCtrlWrite = 1'b0;
    @(negedge clk_sys);
    check32(writeAddrCopy, d);
    check32(readAddrCopy, 32'h0000_3000);
    check32(controlReg, d);
    hostCmd(1'b1, HPPH_SEL_CTRL, 1'b1, 32'h0, {16'h0, d[31:16]}, '1);
    waitReady();
    $display("test cpu address access done");
    check32(32'(qRsp.size() + qWr.size()), 32'h0);
    print_verdict();
  end
endmodule : host_parallel_port_handshake_tb_top

// *** dv/hpph_link_props.sv ***
// Concurrent checks on the pins that join the host end to the device end.
`timescale 1ns/10ps
module hpph_link_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hostChipSelectN,
  input wire logic hostDataStrobeA,
  input wire logic hostDataStrobeB,
  input wire logic addressStrobeN,
  input wire logic [1:0] hostRegisterSelect,
  input wire logic hostReadWrite,
  input wire logic halfwordSelect,
  input wire logic hostReadyN,
  input wire logic devDataOe
);
  logic strobeN;
  logic prevStrobeN;
  logic next_prevStrobeN;
  logic strobeFall;
  logic strobeRise;

  assign strobeN = hostChipSelectN | ~(hostDataStrobeA ^ hostDataStrobeB);
  assign strobeFall = prevStrobeN & ~strobeN;
  assign strobeRise = ~prevStrobeN & strobeN;
  always_comb begin
    next_prevStrobeN = rst ? 1'b1 : strobeN;
  end
  always_ff @(posedge clk_sys) begin
    prevStrobeN <= next_prevStrobeN;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_data_read_wait: assert property (
    strobeFall && hostReadWrite && hostRegisterSelect[0] && !halfwordSelect |=> hostReadyN)
    else $error("data read did not signal wait after strobe fall");
  a_other_no_wait: assert property (
    strobeFall && !hostRegisterSelect[0] |=> !hostReadyN [*3])
    else $error("wait signalled on a register access");
  a_second_half_out: assert property (
    strobeFall && hostReadWrite && halfwordSelect |=> devDataOe && !hostReadyN)
    else $error("second half-word not presented in time");
  a_hold_until_ready: assert property (
    !strobeN && hostReadyN |=> !strobeN)
    else $error("strobe released while device waits");
  a_strobe_low_min: assert property (
    strobeFall |-> (!strobeN) [*4])
    else $error("strobe low phase too short");
  a_strobe_high_min: assert property (
    strobeRise |-> strobeN [*4])
    else $error("strobe high gap too short");
  a_bus_release: assert property (
    strobeRise |=> !devDataOe)
    else $error("data bus not released after strobe rise");
  a_read_drives_bus: assert property (
    strobeFall && hostReadWrite |-> ##[1:10] devDataOe)
    else $error("read never drove the data bus");
  a_addr_strobe_once: assert property (
    !strobeN && !prevStrobeN |-> !$fell(addressStrobeN))
    else $error("second address strobe within one access");
endmodule : hpph_link_props

// *** verilog/hpph_device.sv ***
// Device end of the host parallel port: strobe decode, ready handshake, write buffer.
`timescale 1ns/10ps

module hpph_device
  import hpph_pkg::*;
#(
  parameter int FIFO_DEPTH = HPPH_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  hpph_if.device link,
  input wire logic sixteenBitMode,
  input wire logic cpuCtrlWrite,
  input wire logic cpuReadAddrWrite,
  input wire logic cpuWriteAddrWrite,
  input wire logic [31:0] cpuWriteData,
  output logic [31:0] controlReg,
  output logic [31:0] readAddrCopy,
  output logic [31:0] writeAddrCopy,
  output logic dmaReadReq,
  output logic [31:0] dmaReadAddr,
  input wire logic dmaReadValid,
  input wire logic [31:0] dmaReadData,
  output logic dmaWriteValid,
  input wire logic dmaWriteReady,
  output logic [31:0] dmaWriteAddr,
  output logic [31:0] dmaWriteData
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ_WAIT, ST_READ_HOLD, ST_WRITE_WAIT} hpph_dev_state_t;

  hpph_dev_state_t state, next_state;
  logic strobePrev, addrStrobePrev, selHeld, next_selHeld;
  logic [1:0] heldSelect, next_heldSelect, accSelect, next_accSelect;
  logic heldRead, next_heldRead, heldHalf, next_heldHalf, accHalf, next_accHalf;
  logic readyN, next_readyN, dataOe, next_dataOe, next_dmaReadReq;
  logic [31:0] dataOut, next_dataOut, dataReg, next_dataReg;
  logic [31:0] next_controlReg, next_readAddr, next_writeAddr, next_dmaReadAddr;
  logic [15:0] halfHold, next_halfHold;
  logic strobeNow, strobeFall, strobeRise, addrFall;
  logic [1:0] curSelect;
  logic curRead, curHalf, curData, accData;
  logic [31:0] readWord, readOut;
  logic pushValid, fifoInReady;
  logic [63:0] pushData, popData;

  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] bus,
                                            input logic sixteen, input logic half);
    mergeWord = bus;
    if (sixteen) begin
      mergeWord = half ? {bus[15:0], old[15:0]} : {old[31:16], bus[15:0]};
    end
  endfunction : mergeWord

  // ----------------------------------------------------------------
  // Strobe decode and select capture
  // ----------------------------------------------------------------
  assign strobeNow = ~(link.hostDataStrobeA ^ link.hostDataStrobeB) | link.hostChipSelectN;
  assign strobeFall = strobePrev & ~strobeNow;
  assign strobeRise = ~strobePrev & strobeNow;
  assign addrFall = addrStrobePrev & ~link.addressStrobeN;
  // Selects come from the address strobe capture when one was seen, else from the pins.
  assign curSelect = (selHeld && !addrFall) ? heldSelect : link.hostRegisterSelect;
  assign curRead = (selHeld && !addrFall) ? heldRead : link.hostReadWrite;
  assign curHalf = (selHeld && !addrFall) ? heldHalf : link.halfwordSelect;
  assign curData = (curSelect == HPPH_SEL_DATA_INC) || (curSelect == HPPH_SEL_DATA_FIX);
  assign accData = (accSelect == HPPH_SEL_DATA_INC) || (accSelect == HPPH_SEL_DATA_FIX);
  assign readWord = (curSelect == HPPH_SEL_CTRL) ? controlReg :
                    (curSelect == HPPH_SEL_ADDR) ? readAddrCopy : dataReg;
  assign readOut = !sixteenBitMode ? readWord :
                   (curHalf ? {HPPH_HALF_ZERO, readWord[31:16]} : {HPPH_HALF_ZERO, readWord[15:0]});

  assign link.hostReadyN = readyN;
  assign link.devDataOut = dataOut;
  assign link.devDataOe = dataOe;

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_selHeld = selHeld;
    next_heldSelect = heldSelect;
    next_heldRead = heldRead;
    next_heldHalf = heldHalf;
    next_accSelect = accSelect;
    next_accHalf = accHalf;
    next_readyN = readyN;
    next_dataOe = dataOe;
    next_dataOut = dataOut;
    next_dataReg = dataReg;
    next_halfHold = halfHold;
    next_controlReg = controlReg;
    next_readAddr = readAddrCopy;
    next_writeAddr = writeAddrCopy;
    next_dmaReadAddr = dmaReadAddr;
    next_dmaReadReq = 1'b0;
    pushValid = 1'b0;
    pushData = {writeAddrCopy, link.hostDataBus};
    if (addrFall) begin
      next_selHeld = 1'b1;
      next_heldSelect = link.hostRegisterSelect;
      next_heldRead = link.hostReadWrite;
      next_heldHalf = link.halfwordSelect;
    end
    if (strobeRise) begin
      next_selHeld = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (strobeFall) begin
          next_accSelect = curSelect;
          next_accHalf = curHalf;
          if (curRead && curData && !(sixteenBitMode && curHalf)) begin
            next_dmaReadReq = 1'b1;
            next_dmaReadAddr = readAddrCopy;
            next_readyN = 1'b1;
            next_state = ST_READ_WAIT;
          end else if (curRead) begin
            next_dataOut = readOut;
            next_dataOe = 1'b1;
            next_state = ST_READ_HOLD;
          end else begin
            next_readyN = curData & ~fifoInReady;
            next_state = ST_WRITE_WAIT;
          end
        end
      end
      ST_READ_WAIT: begin
        if (dmaReadValid) begin
          next_dataReg = dmaReadData;
          next_dataOut = sixteenBitMode ? {HPPH_HALF_ZERO, dmaReadData[15:0]} : dmaReadData;
          next_dataOe = 1'b1;
          next_readyN = 1'b0;
          if (accSelect == HPPH_SEL_DATA_INC) begin
            next_readAddr = readAddrCopy + HPPH_ADDR_STEP;
          end
          next_state = ST_READ_HOLD;
        end
      end
      ST_READ_HOLD: begin
        if (strobeRise) begin
          next_dataOe = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_WRITE_WAIT: begin
        next_readyN = accData & ~fifoInReady;
        if (strobeRise) begin
          next_readyN = 1'b0;
          next_state = ST_IDLE;
          if (accData) begin
            if (sixteenBitMode && !accHalf) begin
              next_halfHold = link.hostDataBus[15:0];
            end else begin
              pushValid = 1'b1;
              if (sixteenBitMode) begin
                pushData = {writeAddrCopy, link.hostDataBus[15:0], halfHold};
              end
              if (accSelect == HPPH_SEL_DATA_INC) begin
                next_writeAddr = writeAddrCopy + HPPH_ADDR_STEP;
              end
            end
          end else if (accSelect == HPPH_SEL_CTRL) begin
            next_controlReg = mergeWord(controlReg, link.hostDataBus, sixteenBitMode, accHalf);
          end else begin
            next_readAddr = mergeWord(readAddrCopy, link.hostDataBus, sixteenBitMode, accHalf);
            next_writeAddr = next_readAddr;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // The CPU side reaches the control word and each address copy alone, never the data word.
    if (cpuCtrlWrite) begin
      next_controlReg = cpuWriteData;
    end
    if (cpuReadAddrWrite) begin
      next_readAddr = cpuWriteData;
    end
    if (cpuWriteAddrWrite) begin
      next_writeAddr = cpuWriteData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      strobePrev <= 1'b1;
      addrStrobePrev <= 1'b1;
      selHeld <= 1'b0;
      heldSelect <= HPPH_SEL_CTRL;
      heldRead <= 1'b0;
      heldHalf <= 1'b0;
      accSelect <= HPPH_SEL_CTRL;
      accHalf <= 1'b0;
      readyN <= 1'b0;
      dataOe <= 1'b0;
      dataOut <= '0;
      dataReg <= '0;
      halfHold <= '0;
      controlReg <= HPPH_CTRL_RESET;
      readAddrCopy <= HPPH_ADDR_RESET;
      writeAddrCopy <= HPPH_ADDR_RESET;
      dmaReadAddr <= HPPH_ADDR_RESET;
      dmaReadReq <= 1'b0;
    end else begin
      state <= next_state;
      strobePrev <= strobeNow;
      addrStrobePrev <= link.addressStrobeN;
      selHeld <= next_selHeld;
      heldSelect <= next_heldSelect;
      heldRead <= next_heldRead;
      heldHalf <= next_heldHalf;
      accSelect <= next_accSelect;
      accHalf <= next_accHalf;
      readyN <= next_readyN;
      dataOe <= next_dataOe;
      dataOut <= next_dataOut;
      dataReg <= next_dataReg;
      halfHold <= next_halfHold;
      controlReg <= next_controlReg;
      readAddrCopy <= next_readAddr;
      writeAddrCopy <= next_writeAddr;
      dmaReadAddr <= next_dmaReadAddr;
      dmaReadReq <= next_dmaReadReq;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer toward the DMA address generator
  // ----------------------------------------------------------------
  hpph_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH)
  ) u_write_buffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(dmaWriteValid),
    .outReady(dmaWriteReady),
    .outData(popData)
  );

  assign dmaWriteAddr = popData[63:32];
  assign dmaWriteData = popData[31:0];

endmodule : hpph_device

// *** verilog/hpph_host.sv ***
// Host end of the parallel port, and the write buffer module that the device end uses.
`timescale 1ns/10ps
module hpph_host
  import hpph_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hpph_if.host link,
  input wire logic useAddrStrobe,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [1:0] cmdSelect,
  input wire logic cmdHalf,
  input wire logic [31:0] cmdData,
  output logic rspValid,
  output logic [31:0] rspData
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_ACTIVE, H_RELEASE, H_GAP} hpph_host_state_t;

  hpph_host_state_t state, next_state;
  logic [3:0] count, next_count;
  logic next_cmdReady, next_rspValid;
  logic [31:0] next_rspData, next_dataOut;
  logic chipSelN, next_chipSelN, strobeB, next_strobeB, addrN, next_addrN;
  logic [1:0] regSel, next_regSel;
  logic readWrite, next_readWrite, halfSel, next_halfSel, dataOe, next_dataOe;
  logic [31:0] dataOut;

  assign link.hostChipSelectN = chipSelN;
  assign link.hostDataStrobeA = 1'b0;
  assign link.hostDataStrobeB = strobeB;
  assign link.addressStrobeN = addrN;
  assign link.hostRegisterSelect = regSel;
  assign link.hostReadWrite = readWrite;
  assign link.halfwordSelect = halfSel;
  assign link.hostDataOut = dataOut;
  assign link.hostDataOe = dataOe;

  // ----------------------------------------------------------------
  // Strobe cycle sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    next_cmdReady = cmdReady;
    next_rspValid = 1'b0;
    next_rspData = rspData;
    next_chipSelN = chipSelN;
    next_strobeB = strobeB;
    next_addrN = addrN;
    next_regSel = regSel;
    next_readWrite = readWrite;
    next_halfSel = halfSel;
    next_dataOe = dataOe;
    next_dataOut = dataOut;
    case (state)
      H_IDLE: begin
        if (cmdValid && cmdReady) begin
          next_cmdReady = 1'b0;
          next_regSel = cmdSelect;
          next_readWrite = cmdRead;
          next_halfSel = cmdHalf;
          next_addrN = ~useAddrStrobe;
          next_dataOut = cmdData;
          next_dataOe = ~cmdRead;
          next_state = H_SETUP;
        end
      end
      H_SETUP: begin
        next_chipSelN = 1'b0;
        next_strobeB = 1'b1;
        next_count = '0;
        next_state = H_ACTIVE;
      end
      H_ACTIVE: begin
        next_addrN = 1'b1;
        if (count != HPPH_LOW_LAST) begin
          next_count = count + HPPH_CNT_ONE;
        end else if (!link.hostReadyN) begin
          next_chipSelN = 1'b1;
          next_strobeB = 1'b0;
          next_rspValid = 1'b1;
          next_rspData = readWrite ? link.hostDataBus : rspData;
          next_state = H_RELEASE;
        end
      end
      H_RELEASE: begin
        next_dataOe = 1'b0;
        next_count = '0;
        next_state = H_GAP;
      end
      H_GAP: begin
        if (count != HPPH_HIGH_LAST) begin
          next_count = count + HPPH_CNT_ONE;
        end else begin
          next_cmdReady = 1'b1;
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= H_IDLE;
      count <= '0;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      chipSelN <= 1'b1;
      strobeB <= 1'b0;
      addrN <= 1'b1;
      regSel <= HPPH_SEL_CTRL;
      readWrite <= 1'b1;
      halfSel <= 1'b0;
      dataOe <= 1'b0;
      dataOut <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      cmdReady <= (next_state == H_IDLE) ? 1'b1 : next_cmdReady;
      rspValid <= next_rspValid;
      rspData <= next_rspData;
      chipSelN <= next_chipSelN;
      strobeB <= next_strobeB;
      addrN <= next_addrN;
      regSel <= next_regSel;
      readWrite <= next_readWrite;
      halfSel <= next_halfSel;
      dataOe <= next_dataOe;
      dataOut <= next_dataOut;
    end
  end

endmodule : hpph_host

module hpph_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [CNT_W-1:0] count, next_count;
  logic full, next_full, empty, next_empty;
  logic doPush, doPop;

  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = mem[rdPtr];
  assign doPush = inValid & ~full;
  assign doPop = outReady & ~empty;

  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (doPush) begin
      next_wrPtr = (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
    end
    if (doPop) begin
      next_rdPtr = (rdPtr == PTR_LAST) ? '0 : rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      next_count = count + 1'b1;
    end else if (doPop && !doPush) begin
      next_count = count - 1'b1;
    end
    next_full = (next_count == CNT_FULL);
    next_empty = (next_count == '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      full <= next_full;
      empty <= next_empty;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule : hpph_fifo

// *** verilog/hpph_if.sv ***
// Pin-level link between the external host and the device port.
`timescale 1ns/10ps
interface hpph_if;
  logic hostChipSelectN;
  logic hostDataStrobeA;
  logic hostDataStrobeB;
  logic addressStrobeN;
  logic [1:0] hostRegisterSelect;
  logic hostReadWrite;
  logic halfwordSelect;
  logic hostReadyN;
  logic [31:0] hostDataOut;
  logic hostDataOe;
  logic [31:0] devDataOut;
  logic devDataOe;
  logic [31:0] hostDataBus;

  // The shared data wire: the device driver wins when both are enabled, and it reads zero when neither drives.
  assign hostDataBus = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 32'h0);

  modport device (
    input hostChipSelectN, hostDataStrobeA, hostDataStrobeB, addressStrobeN,
    input hostRegisterSelect, hostReadWrite, halfwordSelect, hostDataBus,
    output hostReadyN, devDataOut, devDataOe
  );

  modport host (
    output hostChipSelectN, hostDataStrobeA, hostDataStrobeB, addressStrobeN,
    output hostRegisterSelect, hostReadWrite, halfwordSelect, hostDataOut, hostDataOe,
    input hostReadyN, hostDataBus
  );
endinterface : hpph_if

// *** verilog/hpph_pkg.sv ***
// Shared constants and timing figures for the host parallel port handshake.
package hpph_pkg;

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int HPPH_DATA_W = 32;
  localparam int HPPH_HALF_W = 16;
  localparam int HPPH_FIFO_DEPTH = 16;
  localparam int HPPH_CNT_W = 4;
  localparam logic [1:0] HPPH_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPPH_SEL_DATA_INC = 2'h1;
  localparam logic [1:0] HPPH_SEL_ADDR = 2'h2;
  localparam logic [1:0] HPPH_SEL_DATA_FIX = 2'h3;
  localparam logic [31:0] HPPH_ADDR_STEP = 32'h4;
  localparam logic [31:0] HPPH_CTRL_RESET = 32'h0;
  localparam logic [31:0] HPPH_ADDR_RESET = 32'h0;
  localparam logic [15:0] HPPH_HALF_ZERO = 16'h0;

  // ----------------------------------------------------------------
  // Timing, in picoseconds and in cycles of clk_sys
  // ----------------------------------------------------------------
  localparam int HPPH_CLK_PS = 20000;
  localparam int HPPH_CPU_P_PS = 20000;
  localparam int HPPH_STROBE_LOW_FLOOR_PS = 12500;
  localparam int HPPH_STROBE_LOW_PS = (4 * HPPH_CPU_P_PS > HPPH_STROBE_LOW_FLOOR_PS) ?
    4 * HPPH_CPU_P_PS : HPPH_STROBE_LOW_FLOOR_PS;
  localparam int HPPH_STROBE_HIGH_PS = 4 * HPPH_CPU_P_PS;
  localparam int HPPH_READY_MAX_PS = 4 * HPPH_CPU_P_PS + 8000;
  localparam int HPPH_BUS_RELEASE_PS = 12000;
  localparam int HPPH_STROBE_LOW_CYC = (HPPH_STROBE_LOW_PS + HPPH_CLK_PS - 1) / HPPH_CLK_PS;
  localparam int HPPH_STROBE_HIGH_CYC = (HPPH_STROBE_HIGH_PS + HPPH_CLK_PS - 1) / HPPH_CLK_PS;
  localparam int HPPH_READY_MAX_CYC = (HPPH_READY_MAX_PS / HPPH_CLK_PS < 1) ?
    1 : HPPH_READY_MAX_PS / HPPH_CLK_PS;
  localparam int HPPH_BUS_RELEASE_CYC = (HPPH_BUS_RELEASE_PS / HPPH_CLK_PS < 1) ?
    1 : HPPH_BUS_RELEASE_PS / HPPH_CLK_PS;
  localparam logic [3:0] HPPH_LOW_LAST = 4'(HPPH_STROBE_LOW_CYC - 1);
  localparam logic [3:0] HPPH_HIGH_LAST = 4'(HPPH_STROBE_HIGH_CYC - 1);
  localparam logic [3:0] HPPH_CNT_ONE = 4'h1;

endpackage : hpph_pkg
